// *** rtl/fbwp_core.sv ***
// Function
// [RL1] power-up single lane; quad only by command
// [RL2] clock idles low or high between frames
// [RL3] sample on rising edge, drive after falling
// [RL4] quad mode carries every phase on four lines
// [RL5] array write-locked after every power-on reset
// [RL6] global unlock clears all write-lock bits; code keeps set those forced by permanent bits
// [RL7] 80 lock bits: pairs for parameter blocks
// [RL8] one is locked; pair msb read-lock
// [RL9] read-locked block reads back zero bytes
// [RL10] lock load needs write unlock first
// [RL11] freeze needs write unlock, then blocks changes
// [RL12] freeze holds until power cycle, shown in status
// [RL13] 72 permanent bits, never erasable
// [RL14] permanent one forces write-lock one forever
// [RL15] permanent zero writes change nothing
// [RL16] permanent write ignored while frozen
// [RL17] protect pin only single/dual and config zero
// [RL18] pin arm bit sticky, factory zero
// [RL19] armed low pin blocks lock and config writes
// [RL20] freeze overrides the protect pin
// [RL21] protect pin never touches array writes
// [RL22] 2 KiB id area, first 8 bytes fixed
// [RL23] sealed id area rejects writes; never erased
// [RL24] status bit 4 freeze, bit 5 sealed
// [RL25] unlock latch clears after load and freeze
// [RL26] config bit 1 disables protect pin
// [RL27] refused writes change no protection state
`timescale 1ns/1ps
module fbwp_core import fbwp_pkg::*; (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // serial link
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic [3:0] shared_io_lines_in,
  output logic [3:0] shared_io_lines_out,
  output logic [3:0] shared_io_lines_oe_out,
  input wire logic wp_n_in,
  // nonvolatile image
  input wire logic [71:0] nv_perm_in,
  input wire logic nv_arm_in,
  input wire logic nv_sealed_in,
  output logic [71:0] nv_perm_out,
  output logic nv_arm_out,
  output logic nv_sealed_out,
  // array access check
  input wire logic [6:0] arr_block_in,
  input wire logic [7:0] arr_data_in,
  output logic arr_write_locked_out,
  output logic [7:0] arr_rdata_out,
  // status
  output logic [7:0] status_out,
  output logic quad_mode_out
);
  fbwp_state_t s_r;
  fbwp_state_t s_nxt;
  logic [6:0] lvl;
  logic sck;
  logic csn;
  logic wp_n;
  logic [3:0] sio;
  logic [7:0] id_rdata;

  fbwp_sync u_sync (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .pin_in({wp_n_in, shared_io_lines_in, cs_n_in, sck_in}),
    .level_out(lvl)
  );

  fbwp_id_mem u_id_mem (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .we_in(s_r.id_we),
    .addr_in(s_r.id_addr),
    .wdata_in(s_r.id_wdata),
    .rdata_out(id_rdata)
  );

  assign sck = lvl[0];
  assign csn = lvl[1];
  assign sio = lvl[5:2];
  assign wp_n = lvl[6];

  // write-lock positions forced by the permanent bits
  function automatic logic [79:0] perm_mask(input logic [71:0] p);
    logic [79:0] m;
    m = {16'h0000, p[63:0]};
    for (int i = 0; i < 8; i++) begin
      m[64 + 2 * i] = p[64 + i];
    end
    return m;
  endfunction

  // index of a parameter block bit: 64 + 2 * block + rd
  function automatic logic [6:0] param_bit(input logic [2:0] blk, input logic rd);
    return {3'h4, blk, rd};
  endfunction

  function automatic logic [7:0] status_byte(input fbwp_state_t s);
    logic [7:0] b;
    b = 8'h00;
    b[SR_WEL_BIT] = s.write_unlock_latch;
    b[SR_LOCKDOWN_BIT] = s.lockdown; // [RL12] [RL24]
    b[SR_SEALED_BIT] = s.sealed; // [RL24]
    return b;
  endfunction

  function automatic logic [7:0] config_byte(input fbwp_state_t s);
    logic [7:0] b;
    b = 8'h00;
    b[CR_IOC_BIT] = s.io_pin_config; // [RL26]
    b[CR_ARM_BIT] = s.arm;
    return b;
  endfunction

  logic wp_block;
  logic rise;
  logic fall;
  logic [7:0] in_byte;
  logic [2:0] in_step;
  logic [7:0] src_byte;
  logic [7:0] cur;
  logic [2:0] ocnt_n;
  logic [79:0] new_bpr;
  logic [71:0] new_perm;

  always_comb begin
    // pin counts only in single/dual lane with config bit zero and armed
    wp_block = !s_r.io_pin_config && s_r.arm && !wp_n && !s_r.quad; // [RL17] [RL19] [RL26]
    rise = sck && !s_r.sck_q; // [RL2] [RL3]
    fall = !sck && s_r.sck_q; // [RL3]
    in_step = s_r.quad ? 3'h4 : 3'h1;
    in_byte = s_r.quad ? {s_r.in_sh[3:0], sio} : {s_r.in_sh[6:0], sio[0]}; // [RL4]
    unique case (s_r.cmd)
      OP_RD_STATUS: src_byte = status_byte(s_r);
      OP_RD_CONFIG: src_byte = config_byte(s_r);
      OP_RD_LOCK: src_byte = s_r.block_lock_map[8'(79 - 8 * s_r.nbytes) -: 8];
      OP_ID_READ: src_byte = id_rdata;
      default: src_byte = 8'h00;
    endcase
    cur = (s_r.ocnt == 3'h0) ? src_byte : s_r.out_sh;
    ocnt_n = s_r.ocnt + in_step;
    new_perm = s_r.perm | s_r.dat_sh[71:0]; // [RL14] [RL15]
    new_bpr = s_r.block_lock_map | perm_mask(new_perm);

    s_nxt = s_r;
    s_nxt.sck_q = sck;
    s_nxt.cs_q = csn;
    s_nxt.id_we = 1'b0;
    s_nxt.id_inc = 1'b0;
    s_nxt.id_addr = s_r.id_addr + {10'h000, s_r.id_inc};
    // array checks follow only the lock bits, never the pin
    if (arr_block_in[6]) begin
      s_nxt.arr_wlock = s_r.block_lock_map[param_bit(arr_block_in[2:0], 1'b0)]; // [RL8] [RL21]
      s_nxt.arr_rdata = s_r.block_lock_map[param_bit(arr_block_in[2:0], 1'b1)] ? 8'h00 : arr_data_in; // [RL9]
    end else begin
      s_nxt.arr_wlock = s_r.block_lock_map[arr_block_in];
      s_nxt.arr_rdata = arr_data_in;
    end

    if (!s_r.nv_loaded) begin
      // first cycle after reset: take the stored nonvolatile image
      s_nxt.nv_loaded = 1'b1;
      s_nxt.perm = nv_perm_in; // [RL13]
      s_nxt.arm = nv_arm_in; // [RL18]
      s_nxt.sealed = nv_sealed_in;
      s_nxt.block_lock_map = BPR_RESET | perm_mask(nv_perm_in); // [RL5] [RL7]
    end else if (csn) begin
      if (!s_r.cs_q && s_r.phase != PH_CMD) begin
        unique case (s_r.cmd)
          OP_WR_UNLOCK: s_nxt.write_unlock_latch = 1'b1;
          OP_WR_RELOCK: s_nxt.write_unlock_latch = 1'b0;
          OP_LOAD_LOCK: begin
            s_nxt.write_unlock_latch = 1'b0; // [RL25]
            if (s_r.write_unlock_latch && !s_r.lockdown && !wp_block && s_r.nbytes == BPR_BYTES) begin // [RL10] [RL20] [RL27]
              s_nxt.block_lock_map = s_r.dat_sh | perm_mask(s_r.perm); // [RL14]
            end
          end
          OP_GLOBAL_UNLOCK: begin
            s_nxt.write_unlock_latch = 1'b0;
            if (s_r.write_unlock_latch && !s_r.lockdown && !wp_block) begin
              s_nxt.block_lock_map = (s_r.block_lock_map & ~BPR_WL_MASK) | perm_mask(s_r.perm); // [RL6]
            end
          end
          OP_FREEZE_LOCK: begin
            s_nxt.write_unlock_latch = 1'b0; // [RL25]
            if (s_r.write_unlock_latch) begin
              s_nxt.lockdown = 1'b1; // [RL11] [RL12]
            end
          end
          OP_PERM_LOCK: begin
            s_nxt.write_unlock_latch = 1'b0;
            if (s_r.write_unlock_latch && !s_r.lockdown && s_r.nbytes == PERM_BYTES) begin // [RL16]
              s_nxt.perm = new_perm; // [RL13]
              s_nxt.block_lock_map = new_bpr; // [RL14]
            end
          end
          OP_WR_CONFIG: begin
            s_nxt.write_unlock_latch = 1'b0;
            if (s_r.write_unlock_latch && !wp_block && s_r.nbytes == WRSR_BYTES) begin // [RL19]
              s_nxt.io_pin_config = s_r.dat_sh[CR_IOC_BIT]; // [RL26]
              s_nxt.arm = s_r.arm | s_r.dat_sh[CR_ARM_BIT]; // [RL18]
            end
          end
          OP_ID_PROGRAM: s_nxt.write_unlock_latch = 1'b0;
          OP_ID_SEAL: begin
            s_nxt.write_unlock_latch = 1'b0;
            if (s_r.write_unlock_latch) begin
              s_nxt.sealed = 1'b1; // [RL23]
            end
          end
          OP_QUAD_ENTER: s_nxt.quad = 1'b1; // [RL1]
          OP_QUAD_EXIT: s_nxt.quad = 1'b0;
          default: s_nxt.write_unlock_latch = s_r.write_unlock_latch;
        endcase
      end
      s_nxt.phase = PH_CMD;
      s_nxt.bitcnt = 3'h0;
      s_nxt.nbytes = 4'h0;
      s_nxt.ocnt = 3'h0;
      s_nxt.drv = 1'b0;
    end else if (rise && !s_r.drv) begin
      s_nxt.in_sh = in_byte;
      s_nxt.bitcnt = s_r.bitcnt + in_step;
      if (s_r.bitcnt + in_step == 3'h0) begin
        unique case (s_r.phase)
          PH_CMD: begin
            s_nxt.cmd = in_byte;
            s_nxt.phase = PH_DATA;
            if (in_byte == OP_RD_STATUS || in_byte == OP_RD_CONFIG || in_byte == OP_RD_LOCK) begin
              s_nxt.drv = 1'b1;
            end else if (in_byte == OP_ID_PROGRAM || in_byte == OP_ID_READ) begin
              s_nxt.phase = PH_ADDR;
            end
          end
          PH_ADDR: begin
            s_nxt.id_addr = {s_r.id_addr[2:0], in_byte};
            s_nxt.nbytes = s_r.nbytes + 4'h1;
            if (s_r.nbytes == ADDR_BYTES - 4'h1) begin
              s_nxt.phase = PH_DATA;
              s_nxt.nbytes = 4'h0;
              s_nxt.drv = (s_r.cmd == OP_ID_READ);
            end
          end
          PH_DATA: begin
            s_nxt.dat_sh = {s_r.dat_sh[71:0], in_byte};
            if (s_r.nbytes != 4'hF) begin
              s_nxt.nbytes = s_r.nbytes + 4'h1;
            end
            if (s_r.cmd == OP_ID_PROGRAM) begin
              s_nxt.id_inc = 1'b1;
              // factory bytes and a sealed area stay untouched
              s_nxt.id_we = s_r.write_unlock_latch && !s_r.sealed && s_r.id_addr >= ID_FACTORY_BYTES; // [RL22] [RL23] [RL27]
              s_nxt.id_wdata = in_byte;
            end
          end
          default: s_nxt.phase = PH_CMD;
        endcase
      end
    end else if (fall && s_r.drv) begin
      // next bits go out after the falling edge
      s_nxt.sio_o = s_r.quad ? cur[7:4] : {2'h0, cur[7], 1'b0}; // [RL3] [RL4]
      s_nxt.out_sh = s_r.quad ? {cur[3:0], 4'h0} : {cur[6:0], 1'b0};
      s_nxt.ocnt = ocnt_n;
      if (ocnt_n == 3'h0) begin
        if (s_r.cmd == OP_ID_READ) begin
          s_nxt.id_inc = 1'b1;
        end else if (s_r.cmd == OP_RD_LOCK) begin
          s_nxt.nbytes = (s_r.nbytes == BPR_BYTES - 4'h1) ? 4'h0 : s_r.nbytes + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r <= '0;
      s_r.block_lock_map <= BPR_RESET; // [RL5]
      s_r.io_pin_config <= IOC_RESET;
      s_r.phase <= PH_CMD;
      s_r.quad <= 1'b0; // [RL1]
      s_r.cs_q <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign shared_io_lines_out = s_r.sio_o;
  assign shared_io_lines_oe_out = !s_r.drv ? 4'h0 : (s_r.quad ? 4'hF : 4'h2);
  assign nv_perm_out = s_r.perm;
  assign nv_arm_out = s_r.arm;
  assign nv_sealed_out = s_r.sealed;
  assign arr_write_locked_out = s_r.arr_wlock;
  assign arr_rdata_out = s_r.arr_rdata;
  assign status_out = status_byte(s_r);
  assign quad_mode_out = s_r.quad;
endmodule

// *** rtl/fbwp_pkg.sv ***
package fbwp_pkg;
  localparam int BPR_W = 80;
  localparam int PERM_W = 72;
  localparam int ID_AW = 11;
  localparam int ID_BYTES = 2048;
  localparam logic [10:0] ID_FACTORY_BYTES = 11'h008;
  localparam logic [3:0] BPR_BYTES = 4'hA;
  localparam logic [3:0] PERM_BYTES = 4'h9;
  localparam logic [3:0] WRSR_BYTES = 4'h2;
  localparam logic [3:0] ADDR_BYTES = 4'h2;
  localparam int SR_WEL_BIT = 1;
  localparam int SR_LOCKDOWN_BIT = 4;
  localparam int SR_SEALED_BIT = 5;
  localparam int CR_IOC_BIT = 1;
  localparam int CR_ARM_BIT = 7;
  localparam logic IOC_RESET = 1'b0;
  localparam logic [79:0] BPR_WL_MASK = {{8{2'h1}}, 64'hFFFF_FFFF_FFFF_FFFF};
  localparam logic [79:0] BPR_RESET = {{8{2'h1}}, 64'hFFFF_FFFF_FFFF_FFFF};
  localparam logic [6:0] SYNC_RESET = 7'h42;
  // command codes
  localparam logic [7:0] OP_WR_UNLOCK = 8'h06;
  localparam logic [7:0] OP_WR_RELOCK = 8'h04;
  localparam logic [7:0] OP_RD_STATUS = 8'h05;
  localparam logic [7:0] OP_RD_CONFIG = 8'h35;
  localparam logic [7:0] OP_WR_CONFIG = 8'h01;
  localparam logic [7:0] OP_LOAD_LOCK = 8'h42;
  localparam logic [7:0] OP_RD_LOCK = 8'h72;
  localparam logic [7:0] OP_FREEZE_LOCK = 8'h8D;
  localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
  localparam logic [7:0] OP_PERM_LOCK = 8'hE8;
  localparam logic [7:0] OP_ID_PROGRAM = 8'hA5;
  localparam logic [7:0] OP_ID_READ = 8'h88;
  localparam logic [7:0] OP_ID_SEAL = 8'h85;
  localparam logic [7:0] OP_QUAD_ENTER = 8'h38;
  localparam logic [7:0] OP_QUAD_EXIT = 8'hFF;

  typedef enum logic [1:0] {PH_CMD, PH_ADDR, PH_DATA} fbwp_phase_t;

  typedef struct packed {
    logic [6:0] s1;
    logic [6:0] s2;
    logic [6:0] s3;
    logic [6:0] q;
  } fbwp_sync_t;

  typedef struct packed {
    logic [79:0] block_lock_map;
    logic [71:0] perm;
    logic arm;
    logic io_pin_config;
    logic lockdown;
    logic sealed;
    logic write_unlock_latch;
    logic quad;
    logic nv_loaded;
    fbwp_phase_t phase;
    logic [7:0] cmd;
    logic [7:0] in_sh;
    logic [2:0] bitcnt;
    logic [3:0] nbytes;
    logic [79:0] dat_sh;
    logic [10:0] id_addr;
    logic id_we;
    logic id_inc;
    logic [7:0] id_wdata;
    logic [7:0] out_sh;
    logic [2:0] ocnt;
    logic drv;
    logic sck_q;
    logic cs_q;
    logic [3:0] sio_o;
    logic arr_wlock;
    logic [7:0] arr_rdata;
  } fbwp_state_t;
endpackage

// *** rtl/fbwp_sync.sv ***
`timescale 1ns/1ps
module fbwp_sync import fbwp_pkg::*; (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // pins
  input wire logic [6:0] pin_in,
  output logic [6:0] level_out
);
  fbwp_sync_t s_r;
  fbwp_sync_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = pin_in;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    // a bit changes only once the second and third stages agree
    for (int i = 0; i < 7; i++) begin
      if (s_r.s2[i] == s_r.s3[i]) begin
        s_nxt.q[i] = s_r.s3[i];
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_r <= {4{SYNC_RESET}};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign level_out = s_r.q;
endmodule

// *** rtl/fbwp_id_mem.sv ***
`timescale 1ns/1ps
module fbwp_id_mem import fbwp_pkg::*; (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // access
  input wire logic we_in,
  input wire logic [10:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem [ID_BYTES];

  always_ff @(posedge core_clk_in) begin
    if (we_in) begin
      mem[addr_in] <= wdata_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= mem[addr_in];
    end
  end
endmodule

// *** dv/fbwp_checker.sv ***
`timescale 1ns/1ps
module fbwp_checker (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // watched ports
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic [6:0] arr_block_in,
  input wire logic [7:0] arr_data_in,
  input wire logic arr_write_locked_out,
  input wire logic [7:0] arr_rdata_out,
  input wire logic [3:0] shared_io_lines_out,
  input wire logic [3:0] shared_io_lines_oe_out,
  input wire logic [71:0] nv_perm_out,
  input wire logic nv_arm_out,
  input wire logic [7:0] status_out,
  input wire logic quad_mode_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  chk_boot_locked: assert property ($rose(rst_n_in) |-> ##1 arr_write_locked_out [*2])
    else $error("array not locked after reset");
  chk_rd_zero: assert property ($past(rst_n_in) && arr_rdata_out != $past(arr_data_in) |->
    arr_rdata_out == 8'h00 && $past(arr_block_in[6])) else $error("read data altered");
  chk_large_rd: assert property ($past(rst_n_in) && !$past(arr_block_in[6]) |->
    arr_rdata_out == $past(arr_data_in)) else $error("large block read masked");
  chk_status_bits: assert property ((status_out & 8'hCD) == 8'h00)
    else $error("unused status bit set");
  chk_seal_kept: assert property (status_out[5] |=> status_out[5])
    else $error("sealed flag dropped");
  chk_perm_only_set: assert property (1'b1 |=> ($past(nv_perm_out) & ~nv_perm_out) == 72'h0)
    else $error("permanent bit cleared");
  chk_arm_kept: assert property (nv_arm_out |=> nv_arm_out)
    else $error("arm bit dropped");
  chk_oe_idle: assert property (cs_n_in [*8] |-> shared_io_lines_oe_out == 4'h0)
    else $error("lines driven while deselected");
  chk_oe_lanes: assert property (shared_io_lines_oe_out != 4'h0 |->
    shared_io_lines_oe_out == (quad_mode_out ? 4'hF : 4'h2)) else $error("wrong lanes driven");
  chk_out_fall: assert property (shared_io_lines_oe_out != 4'h0 && $stable(shared_io_lines_oe_out) &&
    $changed(shared_io_lines_out) |-> !sck_in) else $error("output moved with clock high");
  chk_quad_switch: assert property ($changed(quad_mode_out) |-> cs_n_in)
    else $error("mode changed inside frame");
  cov_quad: cover property ($rose(quad_mode_out));
  cov_freeze: cover property ($rose(status_out[4]));
  cov_rd_zero: cover property (arr_rdata_out == 8'h00 && $past(arr_data_in) != 8'h00);
endmodule
bind fbwp_core fbwp_checker u_chk (.*);

// *** dv/fbwp_host_model.sv ***
`timescale 1ns/1ps
module fbwp_host_model (
  // clock
  input wire logic core_clk_in,
  // serial link
  output logic sck_out,
  output logic cs_n_out,
  output logic [3:0] drv_out,
  input wire logic [3:0] line_in
);
  logic quad = 1'b0;
  logic idle_hi = 1'b0;
  logic [79:0] rd = '0;
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    drv_out = 4'h5;
  end
  task automatic half();
    repeat (8) @(posedge core_clk_in);
    #2;
  endtask
  // one byte out and in, msb first
  task automatic xbyte(input logic [7:0] b);
    for (int i = 0; i < (quad ? 2 : 8); i++) begin
      if (sck_out) sck_out = 1'b0;
      if (quad) drv_out = b[7-4*i -: 4];
      else drv_out[0] = b[7-i];
      half();
      sck_out = 1'b1;
      rd = quad ? {rd[75:0], line_in} : {rd[78:0], line_in[1]};
      half();
    end
    // mode 0 ends each byte low, mode 3 stays high
    if (!idle_hi) sck_out = 1'b0;
  endtask
  // choose the idle clock level while deselected
  task automatic set_idle(input logic hi);
    idle_hi = hi;
    sck_out = hi;
    half();
  endtask
  task automatic frame(input logic [7:0] op, input int n, input logic [79:0] d);
    cs_n_out = 1'b0;
    half();
    xbyte(op);
    for (int k = n - 1; k >= 0; k--) xbyte(d[8*k +: 8]);
    half();
    cs_n_out = 1'b1;
    // released lines must not keep the last value
    drv_out = ~drv_out;
    half();
  endtask
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/1ps
module testbench import fbwp_pkg::*; ();
  localparam logic [79:0] MAP_V = {16'h0002, 64'h20};
  localparam logic [71:0] PERM_P = {8'h02, 64'h8};
  localparam logic [79:0] MAP_F = {16'h0004, 64'h8};
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic wp_n_in = 1'b1;
  logic [71:0] nv_perm_in = '0;
  logic nv_arm_in = 1'b0;
  logic nv_sealed_in = 1'b0;
  logic [6:0] arr_block_in = '0;
  logic [7:0] arr_data_in = 8'hC3;
  logic sck, cs_n;
  logic [3:0] drv, io_out, io_oe, io;
  logic [71:0] nv_perm_out;
  logic nv_arm_out, nv_sealed_out, arr_write_locked_out, quad_mode_out;
  logic [7:0] arr_rdata_out, status_out;
  int error_cnt = 0;
  int checks = 0;
  always #25 core_clk_in = ~core_clk_in;
  assign io = (io_oe & io_out) | (~io_oe & drv);
  fbwp_host_model u_host (.core_clk_in(core_clk_in), .sck_out(sck), .cs_n_out(cs_n), .drv_out(drv), .line_in(io));
  fbwp_core u_fbwp_core (.*, .sck_in(sck), .cs_n_in(cs_n), .shared_io_lines_in(io), .shared_io_lines_out(io_out),
    .shared_io_lines_oe_out(io_oe));
  task automatic cmp(input logic [79:0] got, input logic [79:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic boot();
    rst_n_in = 1'b0;
    repeat (5) @(posedge core_clk_in);
    #2 rst_n_in = 1'b1;
    repeat (10) @(posedge core_clk_in);
    #2;
  endtask
  task automatic op(input logic [7:0] c, input int n = 0, input logic [79:0] d = '0);
    u_host.frame(c, n, d);
  endtask
  task automatic wr(input logic [7:0] c, input int n = 0, input logic [79:0] d = '0);
    op(OP_WR_UNLOCK);
    op(c, n, d);
  endtask
  task automatic rdmap(input logic [79:0] e);
    op(OP_RD_LOCK, 10);
    cmp(u_host.rd, e, "lock map");
  endtask
  task automatic rdst(input logic [7:0] e);
    op(OP_RD_STATUS, 1);
    cmp(u_host.rd[7:0], e, "status");
  endtask
  task automatic arr(input logic [6:0] b, input logic wl, input logic [7:0] rdv);
    arr_block_in = b;
    repeat (2) @(posedge core_clk_in);
    #2;
    cmp({arr_write_locked_out, arr_rdata_out}, {wl, rdv}, "array");
  endtask
  initial begin
    repeat (90000) @(posedge core_clk_in);
    error_cnt++;
    wrap_up();
  end
  initial begin
    boot();
    cmp(quad_mode_out, 1'b0, "quad");
    rdst(8'h00);
    arr(7'd71, 1'b1, 8'hC3);
    rdmap(BPR_RESET);
    op(OP_LOAD_LOCK, 10, MAP_V);
    rdmap(BPR_RESET);
    op(OP_WR_UNLOCK);
    rdst(8'h02);
    op(OP_LOAD_LOCK, 10, MAP_V);
    rdst(8'h00);
    rdmap(MAP_V);
    arr(7'd64, 1'b0, 8'h00);
    arr(7'd5, 1'b1, 8'hC3);
    wr(OP_LOAD_LOCK, 9, MAP_V);
    rdmap(MAP_V);
    wr(OP_GLOBAL_UNLOCK);
    rdmap(MAP_V & ~BPR_WL_MASK);
    wr(OP_PERM_LOCK, 9, PERM_P);
    cmp(nv_perm_out, PERM_P, "perm");
    wr(OP_LOAD_LOCK, 10, '0);
    rdmap(MAP_F);
    wr(OP_PERM_LOCK, 9, '0);
    cmp(nv_perm_out, PERM_P, "perm");
    wr(OP_WR_CONFIG, 2, 16'h0080);
    cmp(nv_arm_out, 1'b1, "arm");
    wp_n_in = 1'b0;
    arr(7'd6, 1'b0, 8'hC3);
    wr(OP_LOAD_LOCK, 10, '1);
    rdmap(MAP_F);
    wr(OP_WR_CONFIG, 2, 16'h0082);
    op(OP_RD_CONFIG, 1);
    cmp(u_host.rd[7:0], 8'h80, "config");
    wp_n_in = 1'b1;
    wr(OP_WR_CONFIG, 2, 16'h0082);
    wp_n_in = 1'b0;
    wr(OP_LOAD_LOCK, 10, '1);
    rdmap('1);
    wr(OP_WR_CONFIG, 2, 16'h0080);
    op(OP_QUAD_ENTER);
    u_host.quad = 1'b1;
    cmp(quad_mode_out, 1'b1, "quad");
    wr(OP_LOAD_LOCK, 10, '0);
    rdmap(MAP_F);
    op(OP_QUAD_EXIT);
    u_host.quad = 1'b0;
    wp_n_in = 1'b1;
    wr(OP_FREEZE_LOCK);
    rdst(8'h10);
    wr(OP_LOAD_LOCK, 10, '1);
    rdmap(MAP_F);
    wr(OP_PERM_LOCK, 9, '1);
    cmp(nv_perm_out, PERM_P, "perm");
    wr(OP_ID_PROGRAM, 3, 24'h00085A);
    op(OP_ID_READ, 3, 24'h000800);
    cmp(u_host.rd[7:0], 8'h5A, "id");
    wr(OP_ID_SEAL);
    rdst(8'h30);
    cmp(status_out, 8'h30, "status port");
    cmp(nv_sealed_out, 1'b1, "sealed");
    wr(OP_ID_PROGRAM, 3, 24'h0008A5);
    op(OP_ID_READ, 3, 24'h000800);
    cmp(u_host.rd[7:0], 8'h5A, "id");
    nv_perm_in = nv_perm_out;
    nv_arm_in = nv_arm_out;
    nv_sealed_in = nv_sealed_out;
    boot();
    rdst(8'h20);
    rdmap(BPR_RESET);
    cmp(nv_arm_out, 1'b1, "arm");
    u_host.set_idle(1'b1);
    rdst(8'h20);
    wr(OP_GLOBAL_UNLOCK);
    rdmap(MAP_F);
    wrap_up();
  end
endmodule
